//--- rtl/program_erase_suspend_filter.sv
// suspend/resume control and opcode filter for the flash command decoder
// Function
// (RULE1) suspend opcode pauses running program or erase
// (RULE2) program suspend refuses writes, erases, programs
// (RULE3) erase suspend refuses status writes and erases
// (RULE4) suspend acts only during program or erase
// (RULE5) suspend completes within suspend latency
// (RULE6) erase suspend accepts write enable
// (RULE7) both suspends accept status register reads
// (RULE8) both suspends accept extended address access
// (RULE9) both suspends accept every array read
// (RULE10) erase suspend accepts page program opcodes
// (RULE11) erase suspend accepts resume opcode
// (RULE12) suspend needs flags clear and busy set
// (RULE13) suspend sets flag now, clears busy later
// (RULE14) resume clears flag, busy back within 200ns
// (RULE15) refused opcodes discarded without any effect
`timescale 1ns/1ns
module program_erase_suspend_filter (
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_op_valid,
  input  wire logic [7:0] i_op_code,
  input  wire logic       i_op_start,
  input  wire logic       i_op_is_erase,
  input  wire logic       i_op_done,
  output logic            o_op_pass,
  output logic            o_op_drop,
  output logic            o_array_hold,
  output logic            o_write_in_progress_flag,
  output logic            o_erase_suspended_flag,
  output logic            o_program_suspended_flag
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  suspend_filter_pkg::phase_t phase_reg;
  suspend_filter_pkg::phase_t phase_next;
  logic busy_reg;
  logic busy_next;
  logic sus_erase_reg;
  logic sus_erase_next;
  logic sus_prog_reg;
  logic sus_prog_next;
  logic erase_kind_reg;
  logic hold_reg;
  logic hold_next;
  logic pass_next;
  logic drop_next;
  logic timer_load;
  logic [suspend_filter_pkg::TIMER_W-1:0] timer_count;
  logic timer_done;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  wire is_suspend = (i_op_code == suspend_filter_pkg::OP_SUSPEND);
  wire is_resume  = (i_op_code == suspend_filter_pkg::OP_RESUME);
  wire any_sus    = sus_erase_reg || sus_prog_reg;

  // RULE7 status reads
  wire is_status_rd = (i_op_code == suspend_filter_pkg::OP_RDSR1) ||
                      (i_op_code == suspend_filter_pkg::OP_RDSR2) ||
                      (i_op_code == suspend_filter_pkg::OP_RDSR3);
  // RULE8 extended address access
  wire is_ear = (i_op_code == suspend_filter_pkg::OP_RD_EAR) ||
                (i_op_code == suspend_filter_pkg::OP_WR_EAR);
  // RULE9 all array reads
  wire is_array_rd = (i_op_code == suspend_filter_pkg::OP_READ3) ||
                     (i_op_code == suspend_filter_pkg::OP_READ4) ||
                     (i_op_code == suspend_filter_pkg::OP_FAST3) ||
                     (i_op_code == suspend_filter_pkg::OP_FAST4) ||
                     (i_op_code == suspend_filter_pkg::OP_DIO3)  ||
                     (i_op_code == suspend_filter_pkg::OP_DIO4)  ||
                     (i_op_code == suspend_filter_pkg::OP_DOUT3) ||
                     (i_op_code == suspend_filter_pkg::OP_DOUT4) ||
                     (i_op_code == suspend_filter_pkg::OP_QIO3)  ||
                     (i_op_code == suspend_filter_pkg::OP_QIO4)  ||
                     (i_op_code == suspend_filter_pkg::OP_QOUT3) ||
                     (i_op_code == suspend_filter_pkg::OP_QOUT4);
  // RULE10 page programs within erase suspend
  wire is_program = (i_op_code == suspend_filter_pkg::OP_PP3)  ||
                    (i_op_code == suspend_filter_pkg::OP_PP4)  ||
                    (i_op_code == suspend_filter_pkg::OP_QPP3) ||
                    (i_op_code == suspend_filter_pkg::OP_QPP4);
  // RULE6 write enable within erase suspend
  wire is_wren = (i_op_code == suspend_filter_pkg::OP_WREN);

  wire allowed_both  = is_status_rd || is_ear || is_array_rd;
  // RULE3 erase suspend: anything else (status writes, erases) is refused
  wire allowed_erase = allowed_both || is_wren || is_program;
  // RULE2 program suspend: only reads and register access get through
  wire allowed_prog  = allowed_both;

  wire allowed = sus_erase_reg ? allowed_erase :
                 sus_prog_reg  ? allowed_prog  : 1'b1;

  // RULE4 RULE12 only a running program or erase, no flag set
  wire suspend_ok = !any_sus && busy_reg && (phase_reg == suspend_filter_pkg::PH_IDLE);
  // RULE11 RULE14 resume needs a flag set and busy clear
  wire resume_ok  = any_sus && !busy_reg && (phase_reg == suspend_filter_pkg::PH_IDLE);

  wire take_suspend = i_op_valid && is_suspend && suspend_ok;
  wire take_resume  = i_op_valid && is_resume && resume_ok;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    phase_next     = phase_reg;
    busy_next      = busy_reg;
    sus_erase_next = sus_erase_reg;
    sus_prog_next  = sus_prog_reg;
    hold_next      = hold_reg;
    pass_next      = 1'b0;
    drop_next      = 1'b0;
    timer_load     = 1'b0;
    timer_count    = suspend_filter_pkg::TSUS_CYCLES;
    unique case (phase_reg)
      suspend_filter_pkg::PH_IDLE: begin
        if (i_op_start) begin
          busy_next = 1'b1;
        end else if (i_op_done) begin
          busy_next = 1'b0;
        end
        if (take_suspend) begin
          // RULE1 RULE13 flag set at once, array paused
          sus_erase_next = erase_kind_reg;
          sus_prog_next  = !erase_kind_reg;
          hold_next      = 1'b1;
          timer_load     = 1'b1;
          phase_next     = suspend_filter_pkg::PH_SUSPENDING;
        end else if (take_resume) begin
          // RULE14 flag drops now, busy returns after the delay
          sus_erase_next = 1'b0;
          sus_prog_next  = 1'b0;
          timer_load     = 1'b1;
          timer_count    = suspend_filter_pkg::TRESUME_CYCLES;
          phase_next     = suspend_filter_pkg::PH_RESUMING;
        end else if (i_op_valid) begin
          // RULE15 refused or ignored opcodes never reach the core
          pass_next = allowed && !is_suspend && !is_resume;
          drop_next = !pass_next;
        end
      end
      suspend_filter_pkg::PH_SUSPENDING: begin
        // RULE5 RULE13 busy clears when suspend latency expires
        drop_next = i_op_valid;
        if (timer_done) begin
          busy_next  = 1'b0;
          phase_next = suspend_filter_pkg::PH_IDLE;
        end
      end
      suspend_filter_pkg::PH_RESUMING: begin
        drop_next = i_op_valid;
        if (timer_done) begin
          busy_next  = 1'b1;
          hold_next  = 1'b0;
          phase_next = suspend_filter_pkg::PH_IDLE;
        end
      end
      default: begin
        phase_next = suspend_filter_pkg::PH_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      phase_reg     <= suspend_filter_pkg::PH_IDLE;
      busy_reg      <= suspend_filter_pkg::RST_FLAG;
      sus_erase_reg <= suspend_filter_pkg::RST_FLAG;
      sus_prog_reg  <= suspend_filter_pkg::RST_FLAG;
      hold_reg      <= suspend_filter_pkg::RST_FLAG;
      o_op_pass     <= 1'b0;
      o_op_drop     <= 1'b0;
    end else if (i_clk_en) begin
      phase_reg     <= phase_next;
      busy_reg      <= busy_next;
      sus_erase_reg <= sus_erase_next;
      sus_prog_reg  <= sus_prog_next;
      hold_reg      <= hold_next;
      o_op_pass     <= pass_next;
      o_op_drop     <= drop_next;
    end
  end

  // kind of the top-level operation; a program nested in an erase
  // suspend must not overwrite it or a later suspend of the resumed erase would raise the program flag
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      erase_kind_reg <= 1'b0;
    end else if (i_clk_en && i_op_start && !any_sus) begin
      erase_kind_reg <= i_op_is_erase;
    end
  end

  latency_timer #(
    .WIDTH (suspend_filter_pkg::TIMER_W)
  ) u_latency_timer (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_load     (timer_load),
    .i_count    (timer_count),
    .o_done     (timer_done)
  );

  assign o_array_hold             = hold_reg;
  assign o_write_in_progress_flag = busy_reg;
  assign o_erase_suspended_flag   = sus_erase_reg;
  assign o_program_suspended_flag = sus_prog_reg;

endmodule // program_erase_suspend_filter

//--- rtl/suspend_filter_pkg.sv
// constants and types for the program/erase suspend command filter
package suspend_filter_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  // worst-case suspend latency; plain default, no figure is printed
  localparam int TSUS_NS       = 20000;
  localparam int TRESUME_NS    = 200;
  localparam int TIMER_W       = 12;
  // longest times round down to whole cycles, never below one
  localparam logic [TIMER_W-1:0] TSUS_CYCLES =
    TIMER_W'((TSUS_NS / CLK_PERIOD_NS) < 1 ? 1 : (TSUS_NS / CLK_PERIOD_NS));
  localparam logic [TIMER_W-1:0] TRESUME_CYCLES =
    TIMER_W'((TRESUME_NS / CLK_PERIOD_NS) < 1 ? 1 : (TRESUME_NS / CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SUSPEND   = 8'h75;
  localparam logic [7:0] OP_RESUME    = 8'h7a;
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_RDSR1     = 8'h05;
  localparam logic [7:0] OP_RDSR2     = 8'h35;
  localparam logic [7:0] OP_RDSR3     = 8'h15;
  localparam logic [7:0] OP_RD_EAR    = 8'hc8;
  localparam logic [7:0] OP_WR_EAR    = 8'hc5;
  localparam logic [7:0] OP_READ3     = 8'h03;
  localparam logic [7:0] OP_READ4     = 8'h13;
  localparam logic [7:0] OP_FAST3     = 8'h0b;
  localparam logic [7:0] OP_FAST4     = 8'h0c;
  localparam logic [7:0] OP_DIO3      = 8'hbb;
  localparam logic [7:0] OP_DIO4      = 8'hbc;
  localparam logic [7:0] OP_DOUT3     = 8'h3b;
  localparam logic [7:0] OP_DOUT4     = 8'h3c;
  localparam logic [7:0] OP_QIO3      = 8'heb;
  localparam logic [7:0] OP_QIO4      = 8'hec;
  localparam logic [7:0] OP_QOUT3     = 8'h6b;
  localparam logic [7:0] OP_QOUT4     = 8'h6c;
  localparam logic [7:0] OP_PP3       = 8'h02;
  localparam logic [7:0] OP_PP4       = 8'h12;
  localparam logic [7:0] OP_QPP3      = 8'h32;
  localparam logic [7:0] OP_QPP4      = 8'h34;

  // ----------------------------------------------------------------
  // reset values and phases
  // ----------------------------------------------------------------
  localparam logic RST_FLAG = 1'b0;

  typedef enum logic [2:0] {
    PH_IDLE       = 3'b001,
    PH_SUSPENDING = 3'b010,
    PH_RESUMING   = 3'b100
  } phase_t;

endpackage

//--- rtl/latency_timer.sv
// one-shot down counter that pulses when a loaded latency runs out
`timescale 1ns/1ns
module latency_timer #(
  parameter int WIDTH = 12
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_done
);

  logic [WIDTH-1:0] count_reg;
  logic             run_reg;
  logic             last_tick;
  logic             done_next;

  assign last_tick = run_reg && (count_reg == WIDTH'(1));
  // done is raised one edge early so the owner acts on the very edge at
  // which the loaded count runs out; a late pulse would overrun the latency
  assign done_next = i_load ? (i_count == WIDTH'(1)) : (run_reg && (count_reg == WIDTH'(2)));

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
      o_done    <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= done_next;
      if (i_load) begin
        count_reg <= i_count;
        run_reg   <= 1'b1;
      end else if (run_reg) begin
        count_reg <= count_reg - WIDTH'(1);
        run_reg   <= !last_tick;
      end
    end
  end

endmodule // latency_timer

//--- dv/suspend_filter_props.sv
// concurrent checks on the suspend filter ports
`timescale 1ns/1ns
module suspend_filter_props (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_clk_en,
  input wire logic       i_op_valid,
  input wire logic [7:0] i_op_code,
  input wire logic       o_op_pass,
  input wire logic       o_op_drop,
  input wire logic       o_array_hold,
  input wire logic       o_write_in_progress_flag,
  input wire logic       o_erase_suspended_flag,
  input wire logic       o_program_suspended_flag
);
  logic        take;
  logic        sus;
  logic        sus_go;
  logic [11:0] sus_cnt_reg;
  assign take   = i_clk_en && i_op_valid;
  assign sus    = o_erase_suspended_flag || o_program_suspended_flag;
  assign sus_go = take && i_op_code == 8'h75 && !sus && o_write_in_progress_flag;
  // cycles since the last accepted suspend, saturating so it never wraps
  always_ff @(posedge i_core_clk) begin
    if (i_reset) sus_cnt_reg <= 12'hfff;
    else if (sus_go) sus_cnt_reg <= 12'h000;
    else if (i_clk_en && sus_cnt_reg != 12'hfff) sus_cnt_reg <= sus_cnt_reg + 12'h001;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  pass_drop_excl_a: assert property (!(o_op_pass && o_op_drop)) else $error("pass with drop");
  suspend_enter_a: assert property (sus_go |=> sus && o_array_hold) else $error("no suspend");
  suspend_idle_a: assert property (take && i_op_code == 8'h75 && !o_write_in_progress_flag
    |=> o_op_drop && $stable(sus)) else $error("idle suspend acted");
  never_pass_a: assert property (take && i_op_code inside {8'h75, 8'h7a} |=> !o_op_pass)
    else $error("suspend or resume forwarded");
  prog_refuse_a: assert property (take && o_program_suspended_flag && i_op_code inside {8'h01, 8'h31,
    8'h11, 8'h44, 8'h42, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h02, 8'h32} |=> o_op_drop) else $error("prog refuse");
  erase_refuse_a: assert property (take && o_erase_suspended_flag && i_op_code inside {8'h01, 8'h31,
    8'h11, 8'h44, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60} |=> o_op_drop) else $error("erase refuse");
  erase_allow_a: assert property (take && o_erase_suspended_flag && !o_write_in_progress_flag && i_op_code
    inside {8'h06, 8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5, 8'h02, 8'h12, 8'h32, 8'h34} |=> o_op_pass)
    else $error("erase allow");
  sus_latency_a: assert property (sus && sus_cnt_reg <= suspend_filter_pkg::TSUS_CYCLES |->
    o_write_in_progress_flag == (sus_cnt_reg != suspend_filter_pkg::TSUS_CYCLES)) else $error("latency");
  resume_timing_a: assert property (take && i_op_code == 8'h7a && sus && !o_write_in_progress_flag
    |=> !sus ##19 !o_write_in_progress_flag ##1 o_write_in_progress_flag && !o_array_hold) else $error("resume");
endmodule // suspend_filter_props
bind program_erase_suspend_filter suspend_filter_props suspend_filter_props_inst (.*);

//--- dv/host_cmd_model.sv
// host model that hands decoded opcodes to the suspend filter
`timescale 1ns/1ns
module host_cmd_model (
  input  wire logic       i_core_clk,
  output logic            o_op_valid,
  output logic [7:0]      o_op_code
);
  initial begin
    o_op_valid = 1'b0;
    o_op_code  = 8'h00;
  end
  // host issues opcodes
  // caller enters just after an edge; the opcode is held over one edge
  task automatic send(input logic [7:0] op);
    o_op_valid = 1'b1;
    o_op_code  = op;
    @(posedge i_core_clk);
    #1;
  endtask
  // released code is inverted so nothing can reuse a stale opcode
  task automatic release_bus();
    o_op_valid = 1'b0;
    o_op_code  = ~o_op_code;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
endmodule // host_cmd_model

//--- dv/tb_program_erase_suspend_filter.sv
// self-checking bench for the suspend filter
`timescale 1ns/1ns
module tb_program_erase_suspend_filter;
  logic       i_core_clk = 1'b0;
  logic       i_reset;
  logic       i_clk_en;
  logic       i_op_start;
  logic       i_op_is_erase;
  logic       i_op_done;
  logic       exp_drop;
  logic       i_op_valid;
  logic [7:0] i_op_code;
  logic       o_op_pass, o_op_drop, o_array_hold;
  logic       o_write_in_progress_flag, o_erase_suspended_flag, o_program_suspended_flag;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         seed = 32'h90b1;
  logic       exp_q[$];
  logic [7:0] ok_l[22] = '{8'h06, 8'h05, 8'h35, 8'h15, 8'hc8, 8'hc5, 8'h03, 8'h13, 8'h0b, 8'h0c, 8'hbb, 8'hbc,
                           8'h3b, 8'h3c, 8'heb, 8'hec, 8'h6b, 8'h6c, 8'h02, 8'h12, 8'h32, 8'h34};
  logic [7:0] bad_l[15] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h42, 8'h02, 8'h32,
                            8'h06, 8'h12, 8'h34};
  host_cmd_model host_cmd_model_inst (.i_core_clk(i_core_clk), .o_op_valid(i_op_valid), .o_op_code(i_op_code));
  program_erase_suspend_filter program_erase_suspend_filter_inst (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_clk_en(i_clk_en), .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_op_start(i_op_start),
    .i_op_is_erase(i_op_is_erase), .i_op_done(i_op_done), .o_op_pass(o_op_pass), .o_op_drop(o_op_drop),
    .o_array_hold(o_array_hold), .o_write_in_progress_flag(o_write_in_progress_flag),
    .o_erase_suspended_flag(o_erase_suspended_flag), .o_program_suspended_flag(o_program_suspended_flag));
  always #5 i_core_clk = ~i_core_clk;
  task automatic fail(input string msg);
    n_mismatch++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask
  task automatic check_flag(input logic got, input logic exp, input string msg);
    total_checks++;
    if (got !== exp) fail(msg);
  endtask
  // each answer pulse consumes the oldest expectation
  always @(negedge i_core_clk) begin
    if (o_op_pass === 1'b1 || o_op_drop === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected answer");
      else begin
        exp_drop = exp_q.pop_front();
        check_flag(o_op_drop === exp_drop && o_op_pass === !exp_drop, 1'b1, "answer kind");
      end
    end
  end
  task automatic issue(input logic [7:0] op, input logic drop);
    exp_q.push_back(drop);
    host_cmd_model_inst.send(op);
  endtask
  task automatic core(input logic start, input logic erase);
    i_op_start = start;
    i_op_done = !start;
    i_op_is_erase = erase;
    host_cmd_model_inst.wait_cycles(1);
    i_op_start = 1'b0;
    i_op_done = 1'b0;
  endtask
  task automatic suspend_run(input logic erase);
    core(1'b1, erase);
    host_cmd_model_inst.send(8'h75);
    check_flag(erase ? o_erase_suspended_flag : o_program_suspended_flag, 1'b1, "suspend flag");
    check_flag(o_array_hold, 1'b1, "hold");
    issue(8'h03, 1'b1);
    host_cmd_model_inst.release_bus();
    host_cmd_model_inst.wait_cycles(int'(suspend_filter_pkg::TSUS_CYCLES));
    check_flag(o_write_in_progress_flag, 1'b0, "busy after suspend");
  endtask
  task automatic resume_run();
    host_cmd_model_inst.send(8'h7a);
    host_cmd_model_inst.release_bus();
    check_flag(o_erase_suspended_flag | o_program_suspended_flag, 1'b0, "resume flags");
    host_cmd_model_inst.wait_cycles(int'(suspend_filter_pkg::TRESUME_CYCLES));
    check_flag(o_write_in_progress_flag & !o_array_hold, 1'b1, "busy after resume");
    core(1'b0, 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    // two suspend latencies plus short scenarios, with fourfold margin
    #(4 * (2 * int'(suspend_filter_pkg::TSUS_CYCLES) + 200) * suspend_filter_pkg::CLK_PERIOD_NS);
    fail("timeout");
    final_report();
  end
  initial begin
    i_reset = 1'b1;
    i_clk_en = 1'b1;
    i_op_start = 1'b0;
    i_op_is_erase = 1'b0;
    i_op_done = 1'b0;
    host_cmd_model_inst.wait_cycles(10);
    i_reset = 1'b0;
    issue(8'h75, 1'b1);
    issue(8'h7a, 1'b1);
    host_cmd_model_inst.release_bus();
    $display("idle test done");
    suspend_run(1'b1);
    issue(8'h75, 1'b1);
    for (int i = 0; i < 22; i++) issue(ok_l[i], 1'b0);
    for (int i = 0; i < 9; i++) issue(bad_l[i], 1'b1);
    for (int i = 0; i < 16; i++) issue(ok_l[$unsigned($random(seed)) % 22], 1'b0);
    host_cmd_model_inst.release_bus();
    host_cmd_model_inst.wait_cycles(2);
    // a frozen clock enable must not take the opcode
    i_clk_en = 1'b0;
    host_cmd_model_inst.send(8'h03);
    i_clk_en = 1'b1;
    host_cmd_model_inst.release_bus();
    core(1'b1, 1'b0);
    issue(8'h7a, 1'b1);
    host_cmd_model_inst.release_bus();
    core(1'b0, 1'b0);
    resume_run();
    $display("erase suspend test done");
    suspend_run(1'b0);
    for (int i = 1; i < 18; i++) issue(ok_l[i], 1'b0);
    for (int i = 0; i < 15; i++) issue(bad_l[i], 1'b1);
    host_cmd_model_inst.release_bus();
    resume_run();
    $display("program suspend test done");
    host_cmd_model_inst.wait_cycles(4);
    check_flag(exp_q.size() == 0, 1'b1, "answers missing");
    final_report();
  end
endmodule // tb_program_erase_suspend_filter
